// ### src/throttle_defs.svh
// Offsets, field positions, reset values and timing counts of the throttle timer block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef THROTTLE_DEFS_SVH
`define THROTTLE_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_STATUS_FIRST 8'h41
`define ADDR_STATUS_SECOND 8'h42
`define ADDR_ALERT_MASK_FIRST 8'h74
`define ADDR_ALERT_MASK_SECOND 8'h75
`define ADDR_CONFIG_THREE 8'h78
`define ADDR_THROTTLE_TIME 8'h79
`define ADDR_THROTTLE_LIMIT 8'h7A
`define ADDR_CONFIG_FIVE 8'h7C
`define ADDR_CONFIG_FOUR 8'h7D

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RESET_MASK 8'h00
`define RESET_CONFIG 8'h00
`define RESET_LIMIT 8'h00
`define UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CFG3_ALERT_EN_BIT 0
`define CFG3_TIMER_EN_BIT 1
`define CFG3_FULL_SPEED_ON_THROTTLE_BIT 2
`define CFG4_FUNC_LSB 0
`define CFG4_FUNC_MSB 1
`define CFG5_DRIVE_A_BIT 5
`define CFG5_DRIVE_LOCAL_BIT 6
`define CFG5_DRIVE_B_BIT 7
`define MASK1_SUMMARY_BIT 7
`define MASK1_FAR_B_BIT 6
`define MASK1_ONCHIP_BIT 5
`define MASK1_FAR_A_BIT 4
`define MASK1_SUPPLY_BIT 2
`define MASK1_CPU_RAIL_BIT 0
`define STATUS2_F4P_BIT 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define STEP_TIME_NS 22760000
`define STEP_CYCLES (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define PRESCALE_W 23
`define TIMER_FULL 8'hFF

`endif

// ### src/throttle_pkg.sv
// Types shared by the throttle timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package throttle_pkg;

  // Function of the second shared pin
  typedef enum logic [1:0] {
    FUNC_SPEED_SENSE = 2'h0,
    FUNC_THROTTLE = 2'h1,
    FUNC_ALERT = 2'h2,
    FUNC_GPIO = 2'h3
  } pin_func_t;

endpackage

// ### src/throttle_timer_if.sv
// Carrier between the register logic and the throttle timer.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface throttle_timer_if;
  logic enable;
  logic active;
  logic clear;
  logic [7:0] value;

  modport ctrl (output enable, output active, output clear, input value);
  modport timer (input enable, input active, input clear, output value);
endinterface
`default_nettype wire

// ### src/pin_sync.sv
// Three-stage synchroniser for an asynchronous pin level.
// Assumes the pin idles high; output changes only once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Stage one is never looked at; glitches die in stages two and three
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level <= 1'b1;
    end else if (s2_reg == s3_reg) begin
      level <= s3_reg;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### src/throttle_timer.sv
// Accumulating throttle assertion timer with saturation and clear on read.
// Assumes active is already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "throttle_defs.svh"
module throttle_timer #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  throttle_timer_if.timer tif
);
  localparam logic [`PRESCALE_W-1:0] LAST_TICK = `PRESCALE_W'(STEP_CYCLES - 1);

  logic [`PRESCALE_W-1:0] prescale_reg;
  logic [7:0] steps_reg;
  logic seen_reg;

  // Prescaler runs only while asserted, so it pauses and resumes
  always_ff @(posedge core_clk) begin
    if (!rst_n || tif.clear) begin
      prescale_reg <= '0;
    end else if (tif.enable && tif.active) begin
      if (prescale_reg == LAST_TICK) begin
        prescale_reg <= '0;
      end else begin
        prescale_reg <= prescale_reg + 1'b1;
      end
    end
  end

  // Steps of one resolution unit; saturating, never wraps
  always_ff @(posedge core_clk) begin
    if (!rst_n || tif.clear) begin
      steps_reg <= 8'h00;
    end else if (tif.enable && tif.active && prescale_reg == LAST_TICK
                 && steps_reg != `TIMER_FULL) begin
      steps_reg <= steps_reg + 8'h01;
    end
  end

  // A clear during assertion re-marks the assertion at once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
    end else if (tif.clear) begin
      seen_reg <= tif.enable && tif.active;
    end else if (tif.enable && tif.active) begin
      seen_reg <= 1'b1;
    end
  end

  assign tif.value = (steps_reg == 8'h00 && seen_reg) ? 8'h01 : steps_reg;
endmodule // throttle_timer
`default_nettype wire

// ### src/throttle_alert_top.sv
// Throttle timer, alert masks, shared pin selection and fan full_speed_on_throttle.
// Assumes a serial-bus engine on core_clk gives one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
`include "throttle_defs.svh"
module throttle_alert_top #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic far_sensor_a_fault,
  input wire logic onchip_temp_fault,
  input wire logic far_sensor_b_fault,
  input wire logic supply_voltage_fault,
  input wire logic cpu_rail_fault,
  input wire logic diode_a_fault,
  input wire logic diode_b_fault,
  input wire logic [3:0] fan_fail,
  input wire logic overheat_exceeded,
  input wire logic overheat_throttle_pin_over_far_a,
  input wire logic overheat_throttle_pin_over_local,
  input wire logic overheat_throttle_pin_over_far_b,
  input wire logic [2:0] fan_running,
  output logic [2:0] full_speed_force,
  output logic alert_pin_out,
  output logic alert_pin_oe_n,
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_n,
  output logic fourth_speed_sense_input,
  output logic gpio_in_level
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] alert_mask_first_reg;
  logic [7:0] alert_mask_second_reg;
  logic [7:0] config_three_reg;
  logic [7:0] throttle_limit_reg;
  logic [7:0] config_five_reg;
  logic [7:0] config_four_reg;

  logic wr_mask1;
  logic wr_mask2;
  logic wr_cfg3;
  logic wr_limit;
  logic wr_cfg5;
  logic wr_cfg4;

  assign wr_mask1 = reg_wr && reg_addr == `ADDR_ALERT_MASK_FIRST;
  assign wr_mask2 = reg_wr && reg_addr == `ADDR_ALERT_MASK_SECOND;
  assign wr_cfg3 = reg_wr && reg_addr == `ADDR_CONFIG_THREE;
  assign wr_limit = reg_wr && reg_addr == `ADDR_THROTTLE_LIMIT;
  assign wr_cfg5 = reg_wr && reg_addr == `ADDR_CONFIG_FIVE;
  assign wr_cfg4 = reg_wr && reg_addr == `ADDR_CONFIG_FOUR;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_mask_first_reg <= `RESET_MASK;
    end else if (wr_mask1) begin
      alert_mask_first_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_mask_second_reg <= `RESET_MASK;
    end else if (wr_mask2) begin
      alert_mask_second_reg <= reg_wdata;
    end
  end

  // Alert and timer functions stay off until software turns them on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_three_reg <= `RESET_CONFIG;
    end else if (wr_cfg3) begin
      config_three_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      throttle_limit_reg <= `RESET_LIMIT;
    end else if (wr_limit) begin
      throttle_limit_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_five_reg <= `RESET_CONFIG;
    end else if (wr_cfg5) begin
      config_five_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_four_reg <= `RESET_CONFIG;
    end else if (wr_cfg4) begin
      config_four_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Shared pin function
  // ----------------------------------------------------------------
  throttle_pkg::pin_func_t pin_func;
  logic throttle_mode;
  logic alert_on_shared;
  logic timer_enabled;
  logic full_speed_on_throttle_en;
  logic alert_on_first;

  assign pin_func =
    throttle_pkg::pin_func_t'(config_four_reg[`CFG4_FUNC_MSB:`CFG4_FUNC_LSB]);
  assign throttle_mode = pin_func == throttle_pkg::FUNC_THROTTLE;
  assign alert_on_shared = pin_func == throttle_pkg::FUNC_ALERT;
  assign alert_on_first = config_three_reg[`CFG3_ALERT_EN_BIT];
  // Timing needs both the pin function and the separate enable
  assign timer_enabled = throttle_mode && config_three_reg[`CFG3_TIMER_EN_BIT];
  assign full_speed_on_throttle_en = config_three_reg[`CFG3_FULL_SPEED_ON_THROTTLE_BIT];

  logic pin_level;

  pin_sync u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(shared_pin_in),
    .level(pin_level)
  );

  logic throttle_low;
  assign throttle_low = throttle_mode && !pin_level;

  // Pin level is passed on only for the function that owns it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fourth_speed_sense_input <= 1'b1;
      gpio_in_level <= 1'b1;
    end else begin
      fourth_speed_sense_input <= (pin_func == throttle_pkg::FUNC_SPEED_SENSE) ? pin_level : 1'b1;
      gpio_in_level <= (pin_func == throttle_pkg::FUNC_GPIO) ? pin_level : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Throttle timer
  // ----------------------------------------------------------------
  throttle_timer_if tif ();
  logic rd_timer;
  logic timer_over_limit;

  assign rd_timer = reg_rd && reg_addr == `ADDR_THROTTLE_TIME;
  assign tif.enable = timer_enabled;
  // Own drive is on the same wire, so it is timed as well
  assign tif.active = throttle_low;
  assign tif.clear = rd_timer;

  throttle_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  // Limit zero trips on bit0 of the first assertion
  assign timer_over_limit = timer_enabled && tif.value > throttle_limit_reg;

  // ----------------------------------------------------------------
  // Sticky status
  // ----------------------------------------------------------------
  logic [7:0] status_one_cond;
  logic [7:0] status_two_cond;
  logic [7:0] status_one_reg;
  logic [7:0] status_two_reg;
  logic rd_status1;
  logic rd_status2;
  logic f4p_cond;

  assign rd_status1 = reg_rd && reg_addr == `ADDR_STATUS_FIRST;
  assign rd_status2 = reg_rd && reg_addr == `ADDR_STATUS_SECOND;
  // In throttle mode the fan-four slot carries the throttle event
  assign f4p_cond = throttle_mode ? timer_over_limit : fan_fail[3];
  assign status_one_cond = {1'b0, far_sensor_b_fault, onchip_temp_fault, far_sensor_a_fault,
                            1'b0, supply_voltage_fault, cpu_rail_fault, 1'b0};
  assign status_two_cond = {diode_b_fault, diode_a_fault, f4p_cond, fan_fail[2:0],
                            overheat_exceeded, 1'b0};

  // A new event in the read cycle wins over the clear
  for (genvar i = 0; i < 8; i++) begin : g_sticky
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        status_one_reg[i] <= 1'b0;
        status_two_reg[i] <= 1'b0;
      end else begin
        status_one_reg[i] <= status_one_cond[i] | (status_one_reg[i] & ~rd_status1);
        status_two_reg[i] <= status_two_cond[i] | (status_two_reg[i] & ~rd_status2);
      end
    end
  end

  logic status_summary;
  assign status_summary = |status_two_reg;

  // ----------------------------------------------------------------
  // Alert request
  // ----------------------------------------------------------------
  logic [7:0] mask_one_aligned;
  logic first_group_alert;
  logic second_group_alert;
  logic alert_request;

  // Cpu rail mask bit sits one place below its status bit
  assign mask_one_aligned = {1'b1,
                             alert_mask_first_reg[`MASK1_FAR_B_BIT],
                             alert_mask_first_reg[`MASK1_ONCHIP_BIT],
                             alert_mask_first_reg[`MASK1_FAR_A_BIT],
                             1'b1,
                             alert_mask_first_reg[`MASK1_SUPPLY_BIT],
                             alert_mask_first_reg[`MASK1_CPU_RAIL_BIT],
                             1'b1};
  assign first_group_alert = |(status_one_reg & ~mask_one_aligned);
  // Host must leave the fan-four mask clear to see throttle alerts
  assign second_group_alert = |(status_two_reg & ~alert_mask_second_reg)
                              & ~alert_mask_first_reg[`MASK1_SUMMARY_BIT];
  assign alert_request = first_group_alert | second_group_alert;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic overheat_throttle_pin_drive;
  assign overheat_throttle_pin_drive = timer_enabled &&
                       ((config_five_reg[`CFG5_DRIVE_A_BIT] && overheat_throttle_pin_over_far_a) ||
                        (config_five_reg[`CFG5_DRIVE_LOCAL_BIT] && overheat_throttle_pin_over_local) ||
                        (config_five_reg[`CFG5_DRIVE_B_BIT] && overheat_throttle_pin_over_far_b));

  // Open drain: only the enable moves, the data stays low
  assign alert_pin_out = 1'b0;
  assign shared_pin_out = 1'b0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_pin_oe_n <= 1'b1;
    end else begin
      alert_pin_oe_n <= !(alert_on_first && alert_request);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shared_pin_oe_n <= 1'b1;
    end else begin
      shared_pin_oe_n <= !((alert_on_shared && alert_request) ||
                           (throttle_mode && overheat_throttle_pin_drive));
    end
  end

  // ----------------------------------------------------------------
  // Fan full_speed_on_throttle
  // ----------------------------------------------------------------
  // Idle fans are left alone so full_speed_on_throttle cannot spin up a stopped fan
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      full_speed_force <= 3'h0;
    end else begin
      full_speed_force <= {3{full_speed_on_throttle_en && throttle_low}} & fan_running;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] read_mux;

  always_comb begin
    case (reg_addr)
      `ADDR_STATUS_FIRST: read_mux = {status_summary, status_one_reg[6:0]};
      `ADDR_STATUS_SECOND: read_mux = status_two_reg;
      `ADDR_ALERT_MASK_FIRST: read_mux = alert_mask_first_reg;
      `ADDR_ALERT_MASK_SECOND: read_mux = alert_mask_second_reg;
      `ADDR_CONFIG_THREE: read_mux = config_three_reg;
      `ADDR_THROTTLE_TIME: read_mux = tif.value;
      `ADDR_THROTTLE_LIMIT: read_mux = throttle_limit_reg;
      `ADDR_CONFIG_FIVE: read_mux = config_five_reg;
      `ADDR_CONFIG_FOUR: read_mux = config_four_reg;
      default: read_mux = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= read_mux;
      end
    end
  end

endmodule // throttle_alert_top
`default_nettype wire

// ### verification/throttle_alert_checker.sv
// Port assertions for the throttle timer and alert block.
// Assumes binding to the block top; keeps shadows of the mask and configuration registers.
`timescale 1ns/1ps
`default_nettype none
module throttle_alert_checker #(
  parameter int unsigned STEP_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [2:0] fan_running,
  input wire logic [2:0] full_speed_force,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe_n,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe_n,
  input wire logic fourth_speed_sense_input,
  input wire logic gpio_in_level
);
  // ----------------------------------------
  // Shadows
  // ----------------------------------------
  logic [7:0] m1_reg, m2_reg, c3_reg, c4_reg, c5_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      m1_reg <= 8'h00;
      m2_reg <= 8'h00;
      c3_reg <= 8'h00;
      c4_reg <= 8'h00;
      c5_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h74) m1_reg <= reg_wdata;
      if (reg_addr == 8'h75) m2_reg <= reg_wdata;
      if (reg_addr == 8'h78) c3_reg <= reg_wdata;
      if (reg_addr == 8'h7D) c4_reg <= reg_wdata;
      if (reg_addr == 8'h7C) c5_reg <= reg_wdata;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read");
  a_mask1_back: assert property (reg_rd && reg_addr == 8'h74 |=>
    (reg_rdata & 8'hF5) == (m1_reg & 8'hF5)) else $error("first mask readback wrong");
  a_mask2_back: assert property (reg_rd && reg_addr == 8'h75 |=>
    (reg_rdata & 8'hFE) == (m2_reg & 8'hFE)) else $error("second mask readback wrong");
  a_alert_off: assert property (!c3_reg[0] [*2] |-> alert_pin_oe_n)
    else $error("first pin alert while disabled");
  a_full_speed_on_throttle_off: assert property (!c3_reg[2] [*2] |-> full_speed_force == 3'h0)
    else $error("full speed forced without full_speed_on_throttle");
  a_full_speed_on_throttle_idle: assert property ((full_speed_force & ~fan_running & ~$past(fan_running)) == 3'h0)
    else $error("stopped fan forced");
  a_drive_idle: assert property ((c5_reg[7:5] == 3'h0 && c4_reg[1:0] != 2'h2) [*2]
    |-> shared_pin_oe_n) else $error("shared pin driven while input only");
  a_sense_off: assert property ((c4_reg[1:0] != 2'h0) [*2] |-> fourth_speed_sense_input)
    else $error("speed sense not idle");
  a_gpio_off: assert property ((c4_reg[1:0] != 2'h3) [*2] |-> gpio_in_level)
    else $error("gpio level not idle");
  a_open_drain: assert property (!alert_pin_out && !shared_pin_out)
    else $error("open drain data not low");
endmodule // throttle_alert_checker
bind throttle_alert_top throttle_alert_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (.core_clk,
  .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .fan_running,
  .full_speed_force, .alert_pin_out, .alert_pin_oe_n, .shared_pin_out, .shared_pin_oe_n,
  .fourth_speed_sense_input, .gpio_in_level);
`default_nettype wire

// ### verification/cpu_hot_model.sv
// Far-side hot signal sinking the shared throttle pin.
// Assumes a pull-up on the pin; lag sets how slowly requests take effect.
`timescale 1ns/1ps
`default_nettype none
module cpu_hot_model (
  input wire logic core_clk,
  input wire logic hot_req,
  input wire logic [3:0] lag,
  input wire logic dev_oe_n,
  output logic pin_level
);
  logic [3:0] cnt_reg = 4'h0;
  logic hot_reg = 1'b0;
  always_ff @(posedge core_clk) begin
    if (hot_req == hot_reg) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg >= lag) begin
      hot_reg <= hot_req;
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Pull-up wins only when neither party sinks the line
  assign pin_level = !(hot_reg || !dev_oe_n);
endmodule // cpu_hot_model
`default_nettype wire

// ### verification/throttle_timer_alert_mask_tb.sv
// Self-checking bench for the throttle timer and alert block.
// Assumes the block's register strobes and a hot signal model on the shared pin.
`timescale 1ns/1ps
`default_nettype none
module throttle_timer_alert_mask_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [11:0] src = 12'h000;
  logic [2:0] thr = 3'h0;
  logic [2:0] run = 3'h0;
  logic hot = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] reg_rdata, d;
  logic [2:0] fsf;
  logic reg_rvalid, pin, al_oe_n, sh_oe_n, sense, gpio;
  int miscompares = 0;
  int total_checks = 0;
  always #2 core_clk = ~core_clk;
  throttle_alert_top #(.STEP_CYCLES(8)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .far_sensor_a_fault(src[2]), .onchip_temp_fault(src[3]), .far_sensor_b_fault(src[4]),
    .supply_voltage_fault(src[1]), .cpu_rail_fault(src[0]), .diode_a_fault(src[5]),
    .diode_b_fault(src[6]), .fan_fail({src[11], src[9:7]}), .overheat_exceeded(src[10]),
    .overheat_throttle_pin_over_far_a(thr[0]), .overheat_throttle_pin_over_local(thr[1]), .overheat_throttle_pin_over_far_b(thr[2]),
    .fan_running(run), .full_speed_force(fsf), .alert_pin_out(), .alert_pin_oe_n(al_oe_n),
    .shared_pin_in(pin), .shared_pin_out(), .shared_pin_oe_n(sh_oe_n),
    .fourth_speed_sense_input(sense), .gpio_in_level(gpio));
  cpu_hot_model hot_src (.core_clk(core_clk), .hot_req(hot), .lag(lag), .dev_oe_n(sh_oe_n),
    .pin_level(pin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rst();
    @(negedge core_clk);
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge core_clk);
    if (n == 4) begin
      miscompares++;
      give_verdict();
    end
    d = reg_rdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    rd(a);
    chk(nm, d & m, e);
  endtask
  // Gap long enough for the synchroniser to settle both ways
  task automatic pulse(input int n);
    hot = 1'b1;
    cyc(n);
    hot = 1'b0;
    cyc(30);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ra [10] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h7C, 8'h7D, 8'h41, 8'h42, 8'h60};
    foreach (ra[i]) rc("reset value", ra[i], 8'hFF, 8'h00);
    chk("alert idle", 8'(al_oe_n), 8'h01);
    wr(8'h74, 8'hF5);
    wr(8'h75, 8'hFE);
    rc("mask one", 8'h74, 8'hF5, 8'hF5);
    rc("mask two", 8'h75, 8'hFE, 8'hFE);
    $display("reset test done");
  endtask
  task automatic t_masks();
    byte unsigned sb [12] = '{1, 2, 4, 5, 6, 6, 7, 2, 3, 4, 1, 5};
    logic [7:0] sa, ma, bm, mb;
    rst();
    wr(8'h78, 8'h01);
    for (int i = 0; i < 12; i++) begin
      sa = (i < 5) ? 8'h41 : 8'h42;
      ma = (i < 5) ? 8'h74 : 8'h75;
      bm = 8'h01 << sb[i];
      mb = (i == 0) ? 8'h01 : bm;
      src[i] = 1'b1;
      cyc(3);
      chk("alert on fault", 8'(al_oe_n), 8'h00);
      wr(ma, mb);
      cyc(3);
      chk("alert masked", 8'(al_oe_n), 8'h01);
      rc("status masked", sa, bm, bm);
      src[i] = 1'b0;
      wr(ma, 8'h00);
      cyc(3);
      chk("alert held", 8'(al_oe_n), 8'h00);
      rc("sticky status", sa, bm, bm);
      cyc(3);
      chk("alert released", 8'(al_oe_n), 8'h01);
      rc("status cleared", sa, bm, 8'h00);
    end
    $display("mask test done");
  endtask
  task automatic t_timer();
    rst();
    wr(8'h7D, 8'h01);
    wr(8'h78, 8'h02);
    wr(8'h7A, 8'hFF);
    pulse(3);
    rc("first assertion", 8'h79, 8'hFF, 8'h01);
    pulse(18);
    pulse(18);
    rc("accumulated", 8'h79, 8'hFF, 8'h04);
    rc("clear on read", 8'h79, 8'hFF, 8'h00);
    lag = 4'h5;
    pulse(2100);
    lag = 4'h0;
    rc("saturated", 8'h79, 8'hFF, 8'hFF);
    $display("timer test done");
  endtask
  task automatic t_limit();
    rst();
    wr(8'h7D, 8'h01);
    wr(8'h78, 8'h03);
    wr(8'h7A, 8'h01);
    pulse(11);
    rc("below limit", 8'h42, 8'h20, 8'h00);
    pulse(11);
    rc("above limit", 8'h42, 8'h20, 8'h20);
    rd(8'h79);
    rd(8'h42);
    wr(8'h7A, 8'h00);
    hot = 1'b1;
    cyc(12);
    rd(8'h79);
    rc("restart value", 8'h79, 8'hFF, 8'h01);
    chk("alert at first", 8'(al_oe_n), 8'h00);
    rc("flag set", 8'h42, 8'h20, 8'h20);
    wr(8'h75, 8'h20);
    cyc(3);
    chk("throttle masked", 8'(al_oe_n), 8'h01);
    rc("flag kept", 8'h42, 8'h20, 8'h20);
    hot = 1'b0;
    cyc(8);
    rd(8'h79);
    wr(8'h75, 8'h00);
    cyc(3);
    chk("sticky alert", 8'(al_oe_n), 8'h00);
    rc("flag sticky", 8'h42, 8'h20, 8'h20);
    rc("flag cleared", 8'h42, 8'h20, 8'h00);
    $display("limit test done");
  endtask
  task automatic t_pins();
    rst();
    wr(8'h7D, 8'h01);
    wr(8'h78, 8'h04);
    run = 3'b101;
    hot = 1'b1;
    cyc(8);
    chk("full_speed_on_throttle running", 8'(fsf), 8'h05);
    hot = 1'b0;
    cyc(8);
    chk("full_speed_on_throttle released", 8'(fsf), 8'h00);
    wr(8'h78, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(8'h7C, 8'h20 << i);
      thr = ~(3'h1 << i);
      cyc(4);
      chk("drive other", 8'(sh_oe_n), 8'h01);
      thr = 3'h7;
      cyc(4);
      chk("drive own", 8'(sh_oe_n), 8'h00);
      thr = 3'h0;
      cyc(4);
    end
    wr(8'h7D, 8'h00);
    hot = 1'b1;
    cyc(8);
    chk("sense low", 8'(sense), 8'h00);
    wr(8'h7D, 8'h03);
    cyc(3);
    chk("gpio low", 8'(gpio), 8'h00);
    hot = 1'b0;
    rc("drive timed", 8'h42, 8'h20, 8'h20);
    wr(8'h7D, 8'h02);
    src[4] = 1'b1;
    cyc(4);
    chk("shared alert", 8'(sh_oe_n), 8'h00);
    src[4] = 1'b0;
    rd(8'h41);
    cyc(3);
    chk("shared alert off", 8'(sh_oe_n), 8'h01);
    $display("pin test done");
  endtask
  initial begin
    cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_timer();
    t_limit();
    t_pins();
    give_verdict();
  end
endmodule // throttle_timer_alert_mask_tb
`default_nettype wire
